// File: art_pkg.sv
`default_nettype none
package art_pkg;

    // timer control register location and layout
    localparam logic [7:0] ART_CTRL_ADDR     = 8'h91;
    localparam logic [7:0] ART_CTRL_PAGE     = 8'h00;
    localparam int         ART_BIT_HIGH_FLAG = 7;
    localparam int         ART_BIT_LOW_FLAG  = 6;
    localparam int         ART_BIT_LOW_IEN   = 5;
    localparam int         ART_BIT_CAP_EN    = 4;
    localparam int         ART_BIT_SPLIT     = 3;
    localparam int         ART_BIT_RUN       = 2;
    localparam int         ART_BIT_XCLK      = 0;

    // reset values
    localparam logic [7:0] ART_CTRL_RESET    = 8'h00;
    localparam logic [7:0] ART_BYTE_RESET    = 8'h00;

    // prescaler figures
    localparam int         ART_SYS_DIV       = 12;
    localparam int         ART_EXT_DIV       = 8;
    localparam logic [3:0] ART_DIV12_LAST    = 4'(ART_SYS_DIV - 1);
    localparam logic [2:0] ART_EXT_LAST      = 3'(ART_EXT_DIV - 1);

    localparam logic [7:0] ART_BYTE_MAX      = 8'hff;

    // software-owned control bits
    typedef struct packed {
        logic split_mode_sel;
        logic run_ctrl;
        logic low_irq_enable;
        logic capture_enable;
        logic external_clock_sel;
        logic high_clock_sel;
        logic low_clock_sel;
        logic timer_irq_enable;
    } art_ctrl_t;

    // software write port for one byte register
    typedef struct packed {
        logic       wr;
        logic [7:0] data;
    } art_bwr_t;

    // tick picked by a half's clock select and the external select
    function automatic logic art_pick_tick(input logic clk_sel,
                                           input logic xclk,
                                           input logic t12,
                                           input logic t8);
        if (clk_sel) begin
            art_pick_tick = 1'b1;
        end else if (xclk) begin
            art_pick_tick = t8;
        end else begin
            art_pick_tick = t12;
        end
    endfunction

endpackage
`default_nettype wire

// File: art_tick.sv
`timescale 1ns/10ps
`default_nettype none
// tick pulses made in the mclk domain; no derived clocks leave this module
module art_tick
    import art_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic ext_osc_in,
    output logic      tick_div12,
    output logic      tick_ext8
);

    logic [3:0] div12_r;
    logic [3:0] div12_nxt;
    logic       sync1_r;
    logic       sync2_r;
    logic       osc_last_r;
    logic [2:0] ext_r;
    logic [2:0] ext_nxt;
    logic       t12_r;
    logic       t12_nxt;
    logic       t8_r;
    logic       t8_nxt;

    always_comb begin
        div12_nxt = (div12_r == ART_DIV12_LAST) ? 4'h0 : div12_r + 4'h1;
        t12_nxt   = (div12_r == ART_DIV12_LAST);
        ext_nxt   = ext_r;
        t8_nxt    = 1'b0;
        // count rising edges of the synchronised oscillator
        if (sync2_r && !osc_last_r) begin
            ext_nxt = ext_r + 3'h1;
            // bit 2 of the divider falls when it wraps from 7 to 0
            t8_nxt  = (ext_r == ART_EXT_LAST);
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            div12_r    <= 4'h0;
            sync1_r    <= 1'b0;
            sync2_r    <= 1'b0;
            osc_last_r <= 1'b0;
            ext_r      <= 3'h0;
            t12_r      <= 1'b0;
            t8_r       <= 1'b0;
        end else begin
            div12_r    <= div12_nxt;
            sync1_r    <= ext_osc_in;
            sync2_r    <= sync1_r;
            osc_last_r <= sync2_r;
            ext_r      <= ext_nxt;
            t12_r      <= t12_nxt;
            t8_r       <= t8_nxt;
        end
    end

    assign tick_div12 = t12_r;
    assign tick_ext8  = t8_r;

endmodule // art_tick
`default_nettype wire

// File: art_half.sv
`timescale 1ns/10ps
`default_nettype none
// one byte half of the counter; software write beats load beats increment
module art_half
    import art_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       inc,
    input  wire logic       load,
    input  wire logic [7:0] load_val,
    input  wire art_bwr_t   sw_wr,
    output logic [7:0]      count,
    output logic            at_max
);

    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (sw_wr.wr) begin
            cnt_nxt = sw_wr.data;
        end else if (load) begin
            cnt_nxt = load_val;
        end else if (inc) begin
            cnt_nxt = cnt_r + 8'h01;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_r <= ART_BYTE_RESET;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign count  = cnt_r;
    assign at_max = (cnt_r == ART_BYTE_MAX);

endmodule // art_half
`default_nettype wire

// File: art_timer.sv
`timescale 1ns/10ps
`default_nettype none
module art_timer
    import art_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ext_osc_in,
    input  wire art_ctrl_t  ctrl,
    input  wire logic       clr_high_flag,
    input  wire logic       clr_low_flag,
    input  wire art_bwr_t   wr_count_low,
    input  wire art_bwr_t   wr_count_high,
    input  wire art_bwr_t   wr_reload_low,
    input  wire art_bwr_t   wr_reload_high,
    output logic [7:0]      count_low_byte,
    output logic [7:0]      count_high_byte,
    output logic [7:0]      reload_low_byte,
    output logic [7:0]      reload_high_byte,
    output logic [7:0]      timer_control_reg,
    output logic            high_overflow_flag,
    output logic            low_overflow_flag,
    output logic            irq_req
);

    logic       tick_div12;
    logic       tick_ext8;
    logic       low_tick;
    logic       high_tick;
    logic       low_max;
    logic       high_max;
    logic       low_inc;
    logic       high_inc;
    logic       low_load;
    logic       high_load;
    logic       low_ovf;
    logic       high_ovf;
    logic       capture_evt;

    logic [7:0] rl_low_r;
    logic [7:0] rl_low_nxt;
    logic [7:0] rl_high_r;
    logic [7:0] rl_high_nxt;
    logic       hflag_r;
    logic       hflag_nxt;
    logic       lflag_r;
    logic       lflag_nxt;
    logic       irq_r;
    logic       irq_nxt;
    logic [7:0] ctl_r;
    logic [7:0] ctl_nxt;

    art_tick u_tick (
        .mclk       (mclk),
        .rst        (rst),
        .ext_osc_in (ext_osc_in),
        .tick_div12 (tick_div12),
        .tick_ext8  (tick_ext8)
    );

    // tick selection and counting enables
    always_comb begin
        if (ctrl.capture_enable) begin
            // ext/8 is the measured clock here, so it cannot also clock the low byte
            low_tick = ctrl.low_clock_sel ? 1'b1 : tick_div12;
        end else begin
            low_tick = art_pick_tick(ctrl.low_clock_sel, ctrl.external_clock_sel,
                                     tick_div12, tick_ext8);
        end
        high_tick = art_pick_tick(ctrl.high_clock_sel, ctrl.external_clock_sel,
                                  tick_div12, tick_ext8);
        capture_evt = ctrl.capture_enable && tick_ext8;

        if (ctrl.split_mode_sel) begin
            low_inc   = low_tick;
            high_inc  = ctrl.run_ctrl && high_tick;
            low_ovf   = low_inc && low_max;
            high_ovf  = high_inc && high_max;
            low_load  = low_ovf;
            high_load = high_ovf;
        end else begin
            low_inc   = ctrl.run_ctrl && low_tick;
            low_ovf   = low_inc && low_max;
            // high byte takes the carry out of the low byte
            high_inc  = low_ovf;
            high_ovf  = low_ovf && high_max;
            low_load  = high_ovf;
            high_load = high_ovf;
        end
    end

    art_half u_low (
        .mclk     (mclk),
        .rst      (rst),
        .inc      (low_inc),
        .load     (low_load),
        .load_val (rl_low_r),
        .sw_wr    (wr_count_low),
        .count    (count_low_byte),
        .at_max   (low_max)
    );

    art_half u_high (
        .mclk     (mclk),
        .rst      (rst),
        .inc      (high_inc),
        .load     (high_load),
        .load_val (rl_high_r),
        .sw_wr    (wr_count_high),
        .count    (count_high_byte),
        .at_max   (high_max)
    );

    // reload pair, flags, interrupt request, control readback
    always_comb begin
        rl_low_nxt  = rl_low_r;
        rl_high_nxt = rl_high_r;
        if (capture_evt) begin
            rl_low_nxt  = count_low_byte;
            rl_high_nxt = count_high_byte;
        end else begin
            if (wr_reload_low.wr) begin
                rl_low_nxt = wr_reload_low.data;
            end
            if (wr_reload_high.wr) begin
                rl_high_nxt = wr_reload_high.data;
            end
        end

        // a hardware set in the same cycle as a clear wins
        hflag_nxt = hflag_r;
        if (clr_high_flag) begin
            hflag_nxt = 1'b0;
        end
        if (high_ovf || capture_evt) begin
            hflag_nxt = 1'b1;
        end
        lflag_nxt = lflag_r;
        if (clr_low_flag) begin
            lflag_nxt = 1'b0;
        end
        if (low_ovf) begin
            lflag_nxt = 1'b1;
        end

        // request stays up while a flag it covers is pending
        irq_nxt = ctrl.timer_irq_enable &&
                  (hflag_nxt || (ctrl.low_irq_enable && lflag_nxt));

        ctl_nxt = ART_CTRL_RESET;
        ctl_nxt[ART_BIT_HIGH_FLAG] = hflag_nxt;
        ctl_nxt[ART_BIT_LOW_FLAG]  = lflag_nxt;
        ctl_nxt[ART_BIT_LOW_IEN]   = ctrl.low_irq_enable;
        ctl_nxt[ART_BIT_CAP_EN]    = ctrl.capture_enable;
        ctl_nxt[ART_BIT_SPLIT]     = ctrl.split_mode_sel;
        ctl_nxt[ART_BIT_RUN]       = ctrl.run_ctrl;
        ctl_nxt[ART_BIT_XCLK]      = ctrl.external_clock_sel;
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            rl_low_r  <= ART_BYTE_RESET;
            rl_high_r <= ART_BYTE_RESET;
            hflag_r   <= 1'b0;
            lflag_r   <= 1'b0;
            irq_r     <= 1'b0;
            ctl_r     <= ART_CTRL_RESET;
        end else begin
            rl_low_r  <= rl_low_nxt;
            rl_high_r <= rl_high_nxt;
            hflag_r   <= hflag_nxt;
            lflag_r   <= lflag_nxt;
            irq_r     <= irq_nxt;
            ctl_r     <= ctl_nxt;
        end
    end

    assign reload_low_byte    = rl_low_r;
    assign reload_high_byte   = rl_high_r;
    assign high_overflow_flag = hflag_r;
    assign low_overflow_flag  = lflag_r;
    assign irq_req            = irq_r;
    assign timer_control_reg  = ctl_r;

endmodule // art_timer
`default_nettype wire

// File: art_timer_chk.sv
`timescale 1ns/10ps
`default_nettype none
module art_timer_chk
    import art_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire art_ctrl_t  ctrl,
    input  wire logic       clr_high_flag,
    input  wire logic       clr_low_flag,
    input  wire art_bwr_t   wr_count_low,
    input  wire art_bwr_t   wr_count_high,
    input  wire art_bwr_t   wr_reload_low,
    input  wire art_bwr_t   wr_reload_high,
    input  wire logic [7:0] count_low_byte,
    input  wire logic [7:0] count_high_byte,
    input  wire logic [7:0] reload_low_byte,
    input  wire logic [7:0] reload_high_byte,
    input  wire logic [7:0] timer_control_reg,
    input  wire logic       high_overflow_flag,
    input  wire logic       low_overflow_flag,
    input  wire logic       irq_req
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // writes win over counting and captures overwrite the reload pair, so those cycles are left out
    logic       quiet;
    logic [15:0] cnt;
    assign quiet = !wr_count_low.wr && !wr_count_high.wr && !wr_reload_low.wr
                   && !wr_reload_high.wr && !ctrl.capture_enable;
    assign cnt = {count_high_byte, count_low_byte};
    AST_WRAP16: assert property (quiet && !ctrl.split_mode_sel && ctrl.run_ctrl
        && ctrl.low_clock_sel && cnt == 16'hffff |=> high_overflow_flag
        && cnt == $past({reload_high_byte, reload_low_byte})) else $error("16-bit wrap wrong");
    AST_INC16: assert property (quiet && !ctrl.split_mode_sel && ctrl.run_ctrl
        && ctrl.low_clock_sel && cnt != 16'hffff |=> cnt == 16'($past(cnt) + 16'h0001))
        else $error("16-bit count did not step by one");
    AST_LOW_FREE: assert property (quiet && ctrl.split_mode_sel && !ctrl.run_ctrl
        && ctrl.low_clock_sel && count_low_byte != 8'hff |=> $stable(count_high_byte)
        && count_low_byte == 8'($past(count_low_byte) + 8'h01)) else $error("split run gating");
    AST_LOW_WRAP8: assert property (quiet && ctrl.split_mode_sel && ctrl.low_clock_sel
        && count_low_byte == 8'hff |=> low_overflow_flag
        && count_low_byte == $past(reload_low_byte)) else $error("low byte wrap wrong");
    AST_HIGH_WRAP8: assert property (quiet && ctrl.split_mode_sel && ctrl.run_ctrl
        && ctrl.high_clock_sel && count_high_byte == 8'hff |=> high_overflow_flag
        && count_high_byte == $past(reload_high_byte)) else $error("high byte wrap wrong");
    AST_STICKY_HIGH: assert property (high_overflow_flag && !clr_high_flag
        |=> high_overflow_flag) else $error("high flag dropped without clear");
    AST_STICKY_LOW: assert property (low_overflow_flag && !clr_low_flag
        |=> low_overflow_flag) else $error("low flag dropped without clear");
    AST_IRQ: assert property ($stable(ctrl) |-> irq_req == (ctrl.timer_irq_enable
        && (high_overflow_flag || ctrl.low_irq_enable && low_overflow_flag)))
        else $error("interrupt request does not match flags");
    // flag bits follow the flag registers in step, control bits lag by one cycle
    AST_READBACK: assert property (1'b1 |-> timer_control_reg == {high_overflow_flag,
        low_overflow_flag, $past(ctrl.low_irq_enable), $past(ctrl.capture_enable),
        $past(ctrl.split_mode_sel), $past(ctrl.run_ctrl), 1'b0,
        $past(ctrl.external_clock_sel)}) else $error("control readback wrong");
    cover property (ctrl.capture_enable && $rose(high_overflow_flag));
    cover property (!ctrl.split_mode_sel && $rose(irq_req));
    cover property (ctrl.split_mode_sel && $rose(low_overflow_flag));
endmodule // art_timer_chk
bind art_timer art_timer_chk art_timer_chk_inst (.mclk(mclk), .rst(rst), .ctrl(ctrl),
    .clr_high_flag(clr_high_flag), .clr_low_flag(clr_low_flag), .wr_count_low(wr_count_low),
    .wr_count_high(wr_count_high), .wr_reload_low(wr_reload_low),
    .wr_reload_high(wr_reload_high), .count_low_byte(count_low_byte),
    .count_high_byte(count_high_byte), .reload_low_byte(reload_low_byte),
    .reload_high_byte(reload_high_byte), .timer_control_reg(timer_control_reg),
    .high_overflow_flag(high_overflow_flag), .low_overflow_flag(low_overflow_flag),
    .irq_req(irq_req));
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb
    import art_pkg::*;
;
    logic       mclk = 1'b0;
    logic       rst = 1'b1;
    logic       ext = 1'b0;
    art_ctrl_t  ctrl = '0;
    logic       clr_h = 1'b0;
    logic       clr_l = 1'b0;
    art_bwr_t   wcl = '0, wch = '0, wrl = '0, wrh = '0;
    logic [7:0] cl, ch, rl, rh, trg;
    logic       hf, lf, irq;
    int         err_total = 0;
    int         comparisons = 0;
    int         cyc = 0;
    always #20 mclk = ~mclk;
    art_timer art_timer_inst (.mclk(mclk), .rst(rst), .ext_osc_in(ext), .ctrl(ctrl),
        .clr_high_flag(clr_h), .clr_low_flag(clr_l), .wr_count_low(wcl), .wr_count_high(wch),
        .wr_reload_low(wrl), .wr_reload_high(wrh), .count_low_byte(cl), .count_high_byte(ch),
        .reload_low_byte(rl), .reload_high_byte(rh), .timer_control_reg(trg),
        .high_overflow_flag(hf), .low_overflow_flag(lf), .irq_req(irq));
    task automatic tally_and_finish();
        $display("comparisons=%0d err_total=%0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            err_total++;
            tally_and_finish();
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // all four bytes in one cycle; never call twice in a row without a step
    task automatic load(input logic [15:0] cnt, input logic [15:0] rld);
        wcl = '{1'b1, cnt[7:0]};
        wch = '{1'b1, cnt[15:8]};
        wrl = '{1'b1, rld[7:0]};
        wrh = '{1'b1, rld[15:8]};
        step(1);
        wcl.wr = 1'b0;
        wch.wr = 1'b0;
        wrl.wr = 1'b0;
        wrh.wr = 1'b0;
    endtask
    task automatic clear_flags();
        clr_h = 1'b1;
        clr_l = 1'b1;
        step(1);
        clr_h = 1'b0;
        clr_l = 1'b0;
    endtask
    // clears one flag only, so the two clear inputs are proven independent
    task automatic clear_one(input logic high);
        clr_h = high;
        clr_l = !high;
        step(1);
        clr_h = 1'b0;
        clr_l = 1'b0;
    endtask
    // slow oscillator: six mclk cycles per period keeps the synchroniser honest
    task automatic osc(input int n);
        repeat (n) begin
            ext = 1'b1;
            step(3);
            ext = 1'b0;
            step(3);
        end
    endtask
    // ctrl bits msb first: split run lien capen xclk hclk lclk tien
    initial begin
        step(20);
        rst = 1'b0;
        step(1);
        chk({ch, cl}, 16'h0000);
        chk({rh, rl}, 16'h0000);
        chk({trg, 5'h00, hf, lf, irq}, 16'h0000);
        ctrl = 8'h43;
        load(16'hfffe, 16'h1234);
        step(2);
        chk({ch, cl}, 16'h1234);
        chk(16'({hf, lf, irq}), 16'h0007);
        ctrl = 8'h01;
        step(3);
        chk(16'({hf, lf}), 16'h0003);
        clear_one(1'b1);
        chk(16'({hf, lf, irq}), 16'h0002);
        clear_one(1'b0);
        chk(16'({hf, lf, irq}), 16'h0000);
        ctrl = 8'h43;
        load(16'h00fe, 16'h0000);
        step(2);
        chk({ch, cl}, 16'h0100);
        chk(16'({hf, lf, irq}), 16'h0002);
        ctrl = 8'h63;
        step(1);
        chk(16'(irq), 16'h0001);
        ctrl = 8'h83;
        clear_flags();
        load(16'h55fe, 16'h00a0);
        step(2);
        chk({ch, cl}, 16'h55a0);
        chk(16'({hf, lf, irq}), 16'h0002);
        ctrl = 8'he7;
        clear_flags();
        load(16'hff10, 16'h7700);
        step(1);
        chk({8'h00, ch}, 16'h0077);
        chk(16'({hf, irq}), 16'h0003);
        ctrl = 8'h40;
        clear_flags();
        load(16'h0000, 16'h0000);
        step(120);
        chk({ch, cl}, 16'h000a);
        ctrl = 8'h48;
        load(16'h0000, 16'h0000);
        osc(16);
        step(4);
        chk({ch, cl}, 16'h0002);
        ctrl = 8'h42;
        load(16'h0000, 16'habcd);
        osc(8);
        step(4);
        chk({rh, rl}, 16'habcd);
        chk(16'(hf), 16'h0000);
        ctrl = 8'h52;
        load(16'h0000, 16'habcd);
        osc(8);
        step(4);
        chk(16'({rh, rl} inside {[16'd40:16'd60]}), 16'h0001);
        chk(16'(hf), 16'h0001);
        // capture on mclk/12; the external select must not steer the count
        ctrl = 8'h58;
        load(16'h0000, 16'h0000);
        osc(8);
        step(4);
        chk(16'({rh, rl} inside {[16'd3:16'd4]}), 16'h0001);
        // clear lands on the wrap edge: the hardware set must win
        ctrl = 8'h43;
        clear_flags();
        load(16'hfffe, 16'h0000);
        step(1);
        clear_flags();
        chk(16'({hf, lf}), 16'h0003);
        // reset in mid-run brings every output back to zero
        ctrl = '0;
        rst = 1'b1;
        step(1);
        chk({ch, cl}, 16'h0000);
        chk({trg, 5'h00, hf, lf, irq}, 16'h0000);
        rst = 1'b0;
        step(2);
        chk({rh, rl}, 16'h0000);
        chk({trg, 5'h00, hf, lf, irq}, 16'h0000);
        tally_and_finish();
    end
endmodule // tb
`default_nettype wire
